/* verilog/icc_pkg.sv */
`default_nettype none
package icc_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int ADDR_W = 24;
   localparam int DATA_W = 24;
   localparam int TAG_W  = 17;
   localparam int DISP_W = 7;
   localparam int NSEC   = 8;
   localparam int SEC_W  = 3;
   localparam int WS_W   = 4;
   localparam int IDX_W  = SEC_W + DISP_W;
   // ----------------------------------------
   // control bits and reset values
   // ----------------------------------------
   localparam int CE_BIT = 19;
   localparam int BE_BIT = 10;
   localparam logic [TAG_W-1:0] TAG_RESET = 17'h1FFFF;
   localparam logic [2:0]       ONE_WORD  = 3'h1;
   localparam logic [2:0]       BURST_MAX = 3'h4;
   // ----------------------------------------
   // cache instructions and states
   // ----------------------------------------
   typedef enum logic [2:0] {
      CMD_NONE   = 3'b000,
      CMD_LOCK   = 3'b001,
      CMD_UNLOCK = 3'b010,
      CMD_FREE   = 3'b011,
      CMD_FLUSH  = 3'b100
   } icc_cmd_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_FILL = 1'b1
   } icc_state_t;
endpackage : icc_pkg
`default_nettype wire

/* verilog/icc_match.sv */
`timescale 1ns/1ps
`default_nettype none
module icc_match #(
   parameter int NSEC  = icc_pkg::NSEC,
   parameter int TAG_W = icc_pkg::TAG_W
) (
   // lookup
   input  wire logic [TAG_W-1:0]          i_tag,
   input  wire logic [NSEC*TAG_W-1:0]     i_tags,
   // result
   output logic                           o_hit,
   output logic [icc_pkg::SEC_W-1:0]      o_sector
);
   // ----------------------------------------
   // parallel compare
   // ----------------------------------------
   always_comb begin
      o_hit    = 1'b0;
      o_sector = '0;
      for (int i = 0; i < NSEC; i++) begin
         if (i_tags[i*TAG_W +: TAG_W] == i_tag) begin
            o_hit    = 1'b1;
            o_sector = icc_pkg::SEC_W'(i);
         end
      end
   end
endmodule : icc_match
`default_nettype wire

/* verilog/icc_lru.sv */
`timescale 1ns/1ps
`default_nettype none
module icc_lru #(
   parameter int NSEC = icc_pkg::NSEC,
   parameter int SW   = icc_pkg::SEC_W
) (
   // clock and reset
   input  wire logic            i_clock,
   input  wire logic            i_rst,
   input  wire logic            i_clk_en,
   // control
   input  wire logic            i_init,
   input  wire logic            i_touch,
   input  wire logic [SW-1:0]   i_sector,
   input  wire logic [NSEC-1:0] i_locked,
   // victim
   output logic [SW-1:0]        o_victim,
   output logic                 o_all_locked
);
   logic [SW-1:0] stk      [NSEC];
   logic [SW-1:0] next_stk [NSEC];
   logic          seen;

   // ----------------------------------------
   // move to top of stack
   // ----------------------------------------
   always_comb begin
      seen        = 1'b0;
      next_stk[0] = i_sector;
      for (int i = 1; i < NSEC; i++) begin
         seen        = seen | (stk[i-1] == i_sector);
         next_stk[i] = seen ? stk[i] : stk[i-1];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst || (i_clk_en && i_init)) begin
         for (int i = 0; i < NSEC; i++) stk[i] <= SW'(i);
      end else if (i_clk_en && i_touch) begin
         stk <= next_stk;
      end
   end

   // ----------------------------------------
   // victim: deepest unlocked entry
   // ----------------------------------------
   always_comb begin
      o_victim     = '0;
      o_all_locked = 1'b1;
      for (int i = 0; i < NSEC; i++) begin
         if (!i_locked[stk[i]]) begin
            o_victim     = stk[i];
            o_all_locked = 1'b0;
         end
      end
   end
endmodule : icc_lru
`default_nettype wire

/* verilog/icc_cache.sv */
`timescale 1ns/1ps
`default_nettype none
module icc_cache #(
   parameter int NSEC = icc_pkg::NSEC,
   parameter int WS_W = icc_pkg::WS_W
) (
   // clock and reset
   input  wire logic                        i_clock,
   input  wire logic                        i_rst,
   input  wire logic                        i_clk_en,
   // control registers and wait states
   input  wire logic [icc_pkg::DATA_W-1:0]  i_core_status_register,
   input  wire logic [icc_pkg::DATA_W-1:0]  i_operating_mode_register,
   input  wire logic [WS_W-1:0]             i_bus_wait_state_control,
   // core fetch
   input  wire logic                        i_fetch_req,
   input  wire logic [icc_pkg::ADDR_W-1:0]  i_fetch_addr,
   output logic                             o_fetch_valid,
   output logic [icc_pkg::DATA_W-1:0]       o_fetch_data,
   output logic                             o_busy,
   // cache instructions
   input  wire logic                        i_cmd_valid,
   input  wire icc_pkg::icc_cmd_t           i_cmd_op,
   input  wire logic [icc_pkg::ADDR_W-1:0]  i_cmd_addr,
   output logic                             o_cmd_done,
   output logic                             o_illegal_instr,
   // external program memory
   output logic                             o_mem_rd,
   output logic [icc_pkg::ADDR_W-1:0]       o_mem_addr,
   input  wire logic [icc_pkg::DATA_W-1:0]  i_mem_data,
   // status
   output logic                             o_cache_enabled
);
   localparam int TW = icc_pkg::TAG_W;
   localparam int DW = icc_pkg::DISP_W;
   localparam int SW = icc_pkg::SEC_W;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // tag and displacement split
   function automatic logic [TW-1:0] tag_of(input logic [icc_pkg::ADDR_W-1:0] a);
      tag_of = a[icc_pkg::ADDR_W-1 -: TW];
   endfunction : tag_of

   function automatic logic [DW-1:0] disp_of(input logic [icc_pkg::ADDR_W-1:0] a);
      disp_of = a[DW-1:0];
   endfunction : disp_of

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [icc_pkg::DATA_W-1:0] word_mem [NSEC*(2**DW)];
   logic [(2**DW)-1:0]         valid    [NSEC];
   logic [NSEC*TW-1:0]         tags;
   logic [NSEC-1:0]            locked;

   icc_pkg::icc_state_t        state;
   logic [SW-1:0]              fill_sec;
   logic                       fill_store;
   logic                       fill_first;
   logic [icc_pkg::ADDR_W-1:0] fill_addr;
   logic [2:0]                 fill_left;
   logic [WS_W-1:0]            wcnt;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic                       take;
   logic                       cmd_take;
   logic                       fetch_take;
   logic [icc_pkg::ADDR_W-1:0] look_addr;
   logic                       m_hit;
   logic [SW-1:0]              m_sec;
   logic [SW-1:0]              victim;
   logic                       all_locked;
   logic                       word_ok;
   logic                       hit_ok;
   logic                       fill_start;
   logic                       is_lk;
   logic                       cmd_legal;
   logic                       can_place;
   logic                       alloc;
   logic                       touch;
   logic                       flush;
   logic [SW-1:0]              sel_sec;
   logic [2:0]                 next_len;
   logic                       burst_on;
   logic                       word_done;

   assign take      = i_clk_en && (state == icc_pkg::ST_IDLE);
   assign cmd_take  = take && i_cmd_valid && (i_cmd_op != icc_pkg::CMD_NONE);
   assign fetch_take = take && !cmd_take && i_fetch_req;
   assign look_addr = cmd_take ? i_cmd_addr : i_fetch_addr;
   assign burst_on  = i_operating_mode_register[icc_pkg::BE_BIT];
   assign is_lk     = (i_cmd_op == icc_pkg::CMD_LOCK) || (i_cmd_op == icc_pkg::CMD_UNLOCK);
   assign cmd_legal = cmd_take && o_cache_enabled;
   assign can_place = m_hit || !all_locked;
   assign word_ok   = m_hit && valid[m_sec][disp_of(look_addr)];
   assign sel_sec   = m_hit ? m_sec : victim;
   assign flush     = cmd_legal && (i_cmd_op == icc_pkg::CMD_FLUSH);
   assign word_done = (state == icc_pkg::ST_FILL) && i_clk_en && (wcnt == '0);

   assign hit_ok     = fetch_take && o_cache_enabled && word_ok;
   assign fill_start = fetch_take && !(o_cache_enabled && word_ok);
   // sector miss allocation, on fetch and lock or unlock
   assign alloc = !m_hit && !all_locked && o_cache_enabled
                  && (fetch_take || (cmd_take && is_lk));
   // MRU update on fetch and lock or unlock
   assign touch = o_cache_enabled && can_place && (fetch_take || (cmd_take && is_lk));

   always_comb begin
      next_len = icc_pkg::ONE_WORD;
      if (o_cache_enabled && burst_on) begin
         next_len = icc_pkg::BURST_MAX - {1'b0, look_addr[1:0]};
      end
   end

   icc_match #(
      .NSEC  (NSEC),
      .TAG_W (TW)
   ) u_match (
      .i_tag    (tag_of(look_addr)),
      .i_tags   (tags),
      .o_hit    (m_hit),
      .o_sector (m_sec)
   );

   icc_lru #(
      .NSEC (NSEC),
      .SW   (SW)
   ) u_lru (
      .i_clock      (i_clock),
      .i_rst        (i_rst),
      .i_clk_en     (i_clk_en),
      .i_init       (flush),
      .i_touch      (touch),
      .i_sector     (sel_sec),
      .i_locked     (locked),
      .o_victim     (victim),
      .o_all_locked (all_locked)
   );

   // ----------------------------------------
   // enable bit
   // ----------------------------------------
   // enable follows status bit, off after reset
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cache_enabled <= 1'b0;
      end else if (i_clk_en) begin
         o_cache_enabled <= i_core_status_register[icc_pkg::CE_BIT];
      end
   end

   // ----------------------------------------
   // fill sequencer
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state      <= icc_pkg::ST_IDLE;
         fill_sec   <= '0;
         fill_store <= 1'b0;
         fill_first <= 1'b0;
         fill_addr  <= '0;
         fill_left  <= '0;
         wcnt       <= '0;
         o_busy     <= 1'b0;
         o_mem_rd   <= 1'b0;
         o_mem_addr <= '0;
      end else if (i_clk_en) begin
         unique case (state)
            icc_pkg::ST_IDLE: begin
               if (fill_start) begin
                  state      <= icc_pkg::ST_FILL;
                  fill_sec   <= sel_sec;
                  fill_store <= o_cache_enabled && can_place;
                  fill_first <= 1'b1;
                  fill_addr  <= look_addr;
                  fill_left  <= next_len;
                  wcnt       <= i_bus_wait_state_control;
                  o_busy     <= 1'b1;
                  o_mem_rd   <= 1'b1;
                  o_mem_addr <= look_addr;
               end
            end
            icc_pkg::ST_FILL: begin
               // wait states plus one per read
               if (wcnt != '0) begin
                  wcnt <= wcnt - 1'b1;
               end else if (fill_left == icc_pkg::ONE_WORD) begin
                  state    <= icc_pkg::ST_IDLE;
                  o_busy   <= 1'b0;
                  o_mem_rd <= 1'b0;
               end else begin
                  fill_left  <= fill_left - 1'b1;
                  fill_addr  <= fill_addr + 1'b1;
                  o_mem_addr <= fill_addr + 1'b1;
                  fill_first <= 1'b0;
                  wcnt       <= i_bus_wait_state_control;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // core answer
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_fetch_valid <= 1'b0;
         o_fetch_data  <= '0;
      end else if (i_clk_en) begin
         o_fetch_valid <= 1'b0;
         if (hit_ok) begin
            o_fetch_valid <= 1'b1;
            o_fetch_data  <= word_mem[{m_sec, disp_of(look_addr)}];
         end else if (word_done && fill_first) begin
            o_fetch_valid <= 1'b1;
            o_fetch_data  <= i_mem_data;
         end
      end
   end

   // ----------------------------------------
   // instruction answer
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cmd_done      <= 1'b0;
         o_illegal_instr <= 1'b0;
      end else if (i_clk_en) begin
         o_cmd_done      <= cmd_legal;
         o_illegal_instr <= cmd_take && !o_cache_enabled;
      end
   end

   // ----------------------------------------
   // data array
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (word_done && fill_store) begin
         word_mem[{fill_sec, disp_of(fill_addr)}] <= i_mem_data;
      end
   end

   // ----------------------------------------
   // valid bits
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || flush) begin
         for (int i = 0; i < NSEC; i++) valid[i] <= '0;
      end else if (i_clk_en && alloc) begin
         valid[victim] <= '0;
      end else if (word_done && fill_store) begin
         valid[fill_sec][disp_of(fill_addr)] <= 1'b1;
      end
   end

   // ----------------------------------------
   // tags
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || flush) begin
         tags <= {NSEC{icc_pkg::TAG_RESET}};
      end else if (i_clk_en && alloc) begin
         tags[victim*TW +: TW] <= tag_of(look_addr);
      end
   end

   // ----------------------------------------
   // locks
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst || (cmd_legal && (i_cmd_op == icc_pkg::CMD_FREE)) || flush) begin
         locked <= '0;
      end else if (cmd_legal && is_lk && can_place) begin
         locked[sel_sec] <= (i_cmd_op == icc_pkg::CMD_LOCK);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence seq_fill_start;
      fill_start;
   endsequence
   sequence seq_hit_take;
      hit_ok;
   endsequence

   AST_RESET_DISABLED: assert property ($fell(i_rst) |-> !o_cache_enabled)
      else $error("cache not disabled after reset");
   AST_RESET_STATE: assert property ($fell(i_rst) |-> tags[TW-1:0] == icc_pkg::TAG_RESET
      && locked == '0 && valid[0] == '0)
      else $error("reset state wrong");
   AST_ENABLE_BIT: assert property (i_clk_en |=>
      o_cache_enabled == $past(i_core_status_register[icc_pkg::CE_BIT]))
      else $error("enable does not follow status bit");
   AST_HIT_ANSWER: assert property (seq_hit_take |=> o_fetch_valid && !o_busy)
      else $error("hit not answered next cycle");
   AST_SINGLE_FILL: assert property (seq_fill_start ##0 !burst_on
      |=> fill_left == icc_pkg::ONE_WORD && o_mem_rd)
      else $error("single fill length wrong");
   AST_BURST_LEN: assert property (seq_fill_start ##0 (burst_on && o_cache_enabled)
      |=> fill_left == icc_pkg::BURST_MAX - {1'b0, $past(i_fetch_addr[1:0])})
      else $error("burst length wrong");
   AST_VICTIM_UNLOCKED: assert property (alloc |-> !locked[victim])
      else $error("locked sector chosen as victim");
   AST_ILLEGAL: assert property (cmd_take && !o_cache_enabled
      |=> o_illegal_instr && !o_cmd_done)
      else $error("illegal instruction not flagged");
   AST_FREE_ALL: assert property (cmd_legal && i_cmd_op == icc_pkg::CMD_FREE
      |=> locked == '0 && $stable(tags))
      else $error("free-all wrong");
   AST_FILL_WAIT: assert property (seq_fill_start ##0 (i_bus_wait_state_control == '0)
      |=> o_busy ##1 (o_fetch_valid || !$past(i_clk_en)))
      else $error("fill wait wrong");
endmodule : icc_cache
`default_nettype wire

/* bench/icc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icc_mem_model (
   // controller side
   input  wire logic                       i_clock,
   input  wire logic                       i_clk_en,
   input  wire logic                       i_rd,
   input  wire logic [icc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [icc_pkg::WS_W-1:0]   i_ws,
   output logic      [icc_pkg::DATA_W-1:0] o_data
);
   logic                       last_rd = 1'b0;
   logic [icc_pkg::ADDR_W-1:0] last_a  = '0;
   logic [icc_pkg::WS_W-1:0]   age_q   = '0;
   logic [icc_pkg::WS_W-1:0]   age;
   // ------------------------------
   // age of the current read
   // ------------------------------
   assign age = (i_rd && last_rd && i_addr == last_a) ? age_q + 1'b1 : '0;
   always @(posedge i_clock) begin
      if (i_clk_en) begin
         last_rd <= i_rd;
         last_a  <= i_addr;
         age_q   <= age;
      end
   end
   // word valid only in the last cycle of a read, after i_ws wait cycles
   assign o_data = (i_rd && age == i_ws) ? i_addr ^ 24'h5A5A5A : ~(i_addr ^ 24'h5A5A5A);
endmodule : icc_mem_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ------------------------------
   // signals
   // ------------------------------
   logic                       i_clock = 1'b0;
   logic                       i_rst   = 1'b1;
   logic [icc_pkg::DATA_W-1:0] sr      = '0;
   logic [icc_pkg::DATA_W-1:0] operating_mode_register     = '0;
   logic [icc_pkg::WS_W-1:0]   ws      = 4'h2;
   logic                       req     = 1'b0;
   logic                       cv      = 1'b0;
   icc_pkg::icc_cmd_t          cop     = icc_pkg::CMD_NONE;
   logic [icc_pkg::ADDR_W-1:0] faddr   = '0;
   logic [icc_pkg::ADDR_W-1:0] caddr   = '0;
   logic [icc_pkg::ADDR_W-1:0] last_a  = '0;
   logic                       last_rd = 1'b0;
   logic                       clk_en  = 1'b1;
   logic                       fvalid, busy, done, ill, mrd, cen;
   logic [icc_pkg::DATA_W-1:0] fdata, mdata;
   logic [icc_pkg::ADDR_W-1:0] maddr;
   logic [icc_pkg::ADDR_W-1:0] rds[$];
   int                         failures = 0;
   int                         n_checks = 0;
   int                         cycles   = 0;

   always #10 i_clock = ~i_clock;

   icc_cache dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en),
      .i_core_status_register(sr), .i_operating_mode_register(operating_mode_register),
      .i_bus_wait_state_control(ws), .i_fetch_req(req), .i_fetch_addr(faddr),
      .o_fetch_valid(fvalid), .o_fetch_data(fdata), .o_busy(busy),
      .i_cmd_valid(cv), .i_cmd_op(cop), .i_cmd_addr(caddr), .o_cmd_done(done),
      .o_illegal_instr(ill), .o_mem_rd(mrd), .o_mem_addr(maddr),
      .i_mem_data(mdata), .o_cache_enabled(cen)
   );
   icc_mem_model mem (.i_clock(i_clock), .i_clk_en(clk_en), .i_rd(mrd), .i_addr(maddr),
      .i_ws(ws), .o_data(mdata));

   // ------------------------------
   // read log and timeout
   // ------------------------------
   always @(posedge i_clock) begin
      if (mrd && (!last_rd || maddr != last_a)) rds.push_back(maddr);
      last_rd = mrd;
      last_a  = maddr;
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end

   task automatic chk_bit(string name, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic chk_word(string name, logic [23:0] exp, logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_word

   task automatic test_done();
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   task automatic step(int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : step

   function automatic logic [23:0] sa(int k);
      return 24'(k) << 7;
   endfunction : sa

   // fetch one word, expect n external reads
   task automatic fx(logic [23:0] a, int n);
      int w;
      rds.delete();
      faddr = a;
      req   = 1'b1;
      w     = 0;
      do begin
         step(1);
         w++;
      end while (fvalid !== 1'b1 && w < 200);
      req = 1'b0;
      chk_bit("fetch valid", 1'b1, fvalid);
      chk_word("fetch data", a ^ 24'h5A5A5A, fdata);
      chk_word("answer cycles", (n == 0) ? 24'h1 : 24'(ws) + 24'h2, 24'(w));
      while (busy !== 1'b0 && w < 400) begin
         step(1);
         w++;
      end
      step(1);
      chk_bit("busy end", 1'b0, busy);
      chk_word("read count", 24'(n), 24'(rds.size()));
   endtask : fx

   task automatic cmd(icc_pkg::icc_cmd_t op, logic [23:0] a, logic exp_ill, logic judge);
      logic d;
      logic il;
      d     = 1'b0;
      il    = 1'b0;
      cop   = op;
      caddr = a;
      cv    = 1'b1;
      step(1);
      cv  = 1'b0;
      cop = icc_pkg::CMD_NONE;
      repeat (3) begin
         d  = d | done;
         il = il | ill;
         step(1);
      end
      chk_bit("illegal", exp_ill, il);
      if (judge) chk_bit("cmd done", !exp_ill, d);
   endtask : cmd

   // enable and burst set together; gap after change
   task automatic set_mode(logic ce, logic be);
      sr[icc_pkg::CE_BIT]  = ce;
      operating_mode_register[icc_pkg::BE_BIT] = be;
      step(5);
      chk_bit("enable", ce, cen);
   endtask : set_mode

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_disabled();
      chk_bit("enable", 1'b0, cen);
      fx(24'h000100, 1);
      fx(24'h000100, 1);
      for (int k = 1; k <= 4; k++) cmd(icc_pkg::icc_cmd_t'(3'(k)), sa(2), 1'b1, 1'b1);
   endtask : t_disabled

   task automatic t_single();
      set_mode(1'b1, 1'b0);
      fx(24'h000200, 1);
      fx(24'h000200, 0);
      fx(24'h000201, 1);
      fx(24'h000201, 0);
   endtask : t_single

   task automatic t_burst();
      logic [23:0] a;
      set_mode(1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
         ws = 4'(k);
         a  = 24'h000404 + 24'(k);
         cmd(icc_pkg::CMD_FLUSH, '0, 1'b0, 1'b1);
         fx(a, 4 - k);
         foreach (rds[i]) chk_word("burst addr", a + 24'(i), rds[i]);
         fx(24'h000407, 0);
         fx(a, 0);
      end
      ws = 4'h2;
      set_mode(1'b1, 1'b0);
   endtask : t_burst

   task automatic t_lock();
      cmd(icc_pkg::CMD_FLUSH, '0, 1'b0, 1'b1);
      fx(sa(0), 1);
      cmd(icc_pkg::CMD_LOCK, sa(0) + 24'h5, 1'b0, 1'b1);
      for (int k = 1; k <= 8; k++) fx(sa(k), 1);
      fx(sa(0), 0);
      cmd(icc_pkg::CMD_FREE, '0, 1'b0, 1'b1);
      fx(sa(0), 0);
      for (int k = 9; k <= 16; k++) fx(sa(k), 1);
      fx(sa(0), 1);
   endtask : t_lock

   task automatic t_full();
      cmd(icc_pkg::CMD_FLUSH, '0, 1'b0, 1'b1);
      for (int k = 20; k < 28; k++) cmd(icc_pkg::CMD_LOCK, sa(k), 1'b0, 1'b1);
      fx(sa(20) + 24'h5, 1);
      fx(sa(20) + 24'h5, 0);
      cmd(icc_pkg::CMD_LOCK, sa(30), 1'b0, 1'b0);
      fx(sa(30), 1);
      fx(sa(30), 1);
      cmd(icc_pkg::CMD_UNLOCK, sa(21), 1'b0, 1'b1);
      fx(sa(30), 1);
      fx(sa(30), 0);
      fx(sa(20) + 24'h5, 0);
      cmd(icc_pkg::CMD_FLUSH, '0, 1'b0, 1'b1);
      fx(sa(20) + 24'h5, 1);
      for (int k = 40; k < 48; k++) fx(sa(k), 1);
      fx(sa(20) + 24'h5, 1);
   endtask : t_full

   task automatic t_freeze();
      int w;
      rds.delete();
      faddr = sa(60);
      req   = 1'b1;
      step(1);
      clk_en = 1'b0;
      step(6);
      chk_bit("frozen busy", 1'b1, busy);
      chk_bit("frozen valid", 1'b0, fvalid);
      chk_bit("frozen read", 1'b1, mrd);
      chk_word("frozen addr", sa(60), maddr);
      clk_en = 1'b1;
      w      = 0;
      do begin
         step(1);
         w++;
      end while (fvalid !== 1'b1 && w < 20);
      req = 1'b0;
      chk_word("thawed data", sa(60) ^ 24'h5A5A5A, fdata);
      chk_word("thawed cycles", 24'(ws) + 24'h1, 24'(w));
      step(1);
      chk_bit("busy end", 1'b0, busy);
      chk_word("read count", 24'h1, 24'(rds.size()));
      fx(sa(60), 0);
   endtask : t_freeze

   task automatic t_reset2();
      fx(sa(50), 1);
      fx(sa(50), 0);
      i_rst = 1'b1;
      step(2);
      chk_bit("enable", 1'b0, cen);
      i_rst = 1'b0;
      step(5);
      chk_bit("enable", 1'b1, cen);
      fx(sa(50), 1);
   endtask : t_reset2

   initial begin
      step(6);
      i_rst = 1'b0;
      step(1);
      t_disabled();
      t_single();
      t_burst();
      t_lock();
      t_full();
      t_freeze();
      t_reset2();
      test_done();
   end
endmodule : testbench
`default_nettype wire
